// file: tb/itp_tpa.sv
`timescale 1ns/1ns
module itp_tpa
	import itp_pkg::*;
(
	input wire logic trace_port_clock,
	input wire logic half_i,
	input wire logic strap_low_i,
	input wire logic oe_i,
	input wire logic [2:0] status_i,
	input wire logic sync_i,
	input wire logic [3:0] nib_i,
	output logic pin_o,
	output logic [31:0] addr_o,
	output int grp_o
);
	int cnt = 8;
	logic [31:0] acc;
	logic skip = 1'b0;
	// bias resistor to ground, else released high
	assign pin_o = oe_i ? sync_i : !strap_low_i;
	initial grp_o = 0;
	always @(posedge trace_port_clock)
	begin
		// half rate: each value stands two edges, take the first
		if (skip)
			skip = 1'b0;
		else if (sync_i && status_i == 3'h4)
		begin
			acc = {28'h0, nib_i};
			cnt = 1;
			skip = half_i;
		end
		else if (cnt < 8)
		begin
			acc[cnt*4 +: 4] = nib_i;
			cnt++;
			skip = half_i;
			if (cnt == 8)
			begin
				addr_o <= acc;
				grp_o <= grp_o + 1;
			end
		end
	end
endmodule

// file: tb/itp_trace_monitor.sv
`timescale 1ns/1ns
module itp_trace_monitor
	import itp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic trace_port_clock,
	input wire logic packet_sync_pin_i,
	input wire logic packet_sync_pin_oe_o,
	input wire logic trace_pins_sel_o,
	input wire logic [2:0] pipeline_status_code,
	input wire logic packet_sync_flag,
	input wire logic [3:0] trace_packet_nibble
);
	// ****************************************
	// trace port outputs
	// ****************************************
	logic [7:0] out_neg;
	always_ff @(negedge trace_port_clock)
		out_neg <= {pipeline_status_code, packet_sync_flag, trace_packet_nibble};
	a_launch_rising_only: assert property (@(posedge trace_port_clock) disable iff (rst_i)
		{pipeline_status_code, packet_sync_flag, trace_packet_nibble} == out_neg)
		else $error("trace output moved off the rising edge");
	a_sync_is_branch: assert property (@(posedge trace_port_clock) disable iff (rst_i)
		packet_sync_flag |-> pipeline_status_code == 3'h4) else $error("sync without branch");
	a_sync_short: assert property (@(posedge trace_port_clock) disable iff (rst_i)
		packet_sync_flag [*2] |=> !packet_sync_flag) else $error("sync held too long");
	a_group_gap: assert property (@(posedge trace_port_clock) disable iff (rst_i)
		$fell(packet_sync_flag) |-> !packet_sync_flag [*6]) else $error("group cut short");
	a_status_legal: assert property (@(posedge trace_port_clock) disable iff (rst_i)
		pipeline_status_code inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}) else $error("bad status");
	// ****************************************
	// shared pin strap
	// ****************************************
	a_oe_trace_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		packet_sync_pin_oe_o |-> trace_pins_sel_o) else $error("pin driven in port mode");
	a_strap_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$fell(rst_i) |-> ##3 trace_pins_sel_o != $past(packet_sync_pin_i, 4))
		else $error("strap not applied");
	a_strap_held: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!$past(rst_i, 3) |-> $stable(trace_pins_sel_o)) else $error("pin function changed");
endmodule
bind itp_trace itp_trace_monitor itp_trace_monitor_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.trace_port_clock(trace_port_clock), .packet_sync_pin_i(packet_sync_pin_i),
	.packet_sync_pin_oe_o(packet_sync_pin_oe_o), .trace_pins_sel_o(trace_pins_sel_o),
	.pipeline_status_code(pipeline_status_code), .packet_sync_flag(packet_sync_flag),
	.trace_packet_nibble(trace_packet_nibble));

// file: tb/test_itp_trace.sv
`timescale 1ns/1ns
`include "itp_map.svh"
module test_itp_trace
	import itp_pkg::*;
;
	logic clk, rst, tclk, v, c, b, w, ext, tck, trst, tdi, sh, up, strap_low, half;
	logic [3:0] mm;
	logic [31:0] pc, addr;
	logic tdo, oe, sel, sy, pin;
	logic [2:0] st;
	logic [3:0] nb;
	int grp, error_cnt = 0, total_checks = 0;
	itp_trace itp_trace_i (.clk_sys_i(clk), .rst_i(rst), .trace_port_clock(tclk),
		.core_exec_valid_i(v), .core_exec_cond_i(c), .core_branch_i(b), .core_wait_i(w),
		.core_pc_i(pc), .external_trigger_in(ext), .tck_i(tck), .trst_i(trst), .tdi_i(tdi),
		.cfg_shift_i(sh), .cfg_update_i(up), .tdo_o(tdo), .packet_sync_pin_i(pin),
		.packet_sync_pin_oe_o(oe), .trace_pins_sel_o(sel), .pipeline_status_code(st),
		.packet_sync_flag(sy), .trace_packet_nibble(nb), .mem_map_hit_o(mm));
	itp_tpa itp_tpa_i (.trace_port_clock(tclk), .half_i(half), .strap_low_i(strap_low), .oe_i(oe),
		.status_i(st), .sync_i(sy), .nib_i(nb), .pin_o(pin), .addr_o(addr), .grp_o(grp));
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		tclk = 0;
		#1;
		forever #3 tclk = ~tclk;
	end
	// ****************************************
	// helpers
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task do_reset(input logic low);
		@(posedge clk);
		strap_low <= low;
		rst <= 1'b1;
		trst <= 1'b1;
		repeat (16) @(posedge clk) tck <= ~tck;
		rst <= 1'b0;
		trst <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task tck_pulse;
		@(posedge clk) tck <= 1'b1;
		@(posedge clk) tck <= 1'b0;
	endtask
	task cfg(input logic en, input logic [1:0] gate, input logic hf, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [`ITP_CFG_W-1:0] d;
		d = '0;
		d[`ITP_CFG_EN] = en;
		d[`ITP_CFG_SEL] = gate;
		d[`ITP_CFG_HALF] = hf;
		d[`ITP_CFG_LO] = lo;
		d[`ITP_CFG_HI] = hi;
		d[`ITP_CFG_MMD] = {4'h0, {4{en}}};
		@(posedge clk) sh <= 1'b1;
		for (int i = 0; i < `ITP_CFG_W; i++)
		begin
			tdi <= d[i];
			tck_pulse;
		end
		sh <= 1'b0;
		up <= 1'b1;
		half <= hf;
		tck_pulse;
		up <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task br(input logic [31:0] a);
		@(posedge clk);
		b <= 1'b1;
		pc <= a;
		@(posedge clk);
		b <= 1'b0;
		pc <= a + 32'h4;
	endtask
	task settle;
		repeat (40) @(posedge clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_idle;
		chk(sel, 1'b1);
		chk(oe, 1'b1);
		chk(sy, 1'b0);
		chk(st == 3'h4, 1'b0);
	endtask
	task t_branch;
		cfg(1'b1, `ITP_SEL_ALWAYS, 1'b0, 32'h0, 32'h0);
		chk(tdo, 1'b1);
		br(32'h1234_5678);
		br(32'h0000_1000);
		settle;
		chk(grp, 1);
		chk(addr, 32'h1234_5678);
		br(32'hfedc_ba98);
		settle;
		chk(addr, 32'hfedc_ba98);
	endtask
	task t_off;
		cfg(1'b0, `ITP_SEL_ALWAYS, 1'b0, 32'h0, 32'h0);
		br(32'h0000_0040);
		settle;
		chk(grp, 2);
		chk(mm, 4'h0);
	endtask
	task t_ext;
		cfg(1'b1, `ITP_SEL_EXT, 1'b0, 32'h0, 32'h0);
		br(32'h0000_0080);
		settle;
		chk(grp, 2);
		ext <= 1'b1;
		settle;
		br(32'h0000_00c0);
		settle;
		chk(addr, 32'h0000_00c0);
	endtask
	task t_cmp;
		int g0;
		cfg(1'b1, `ITP_SEL_CMP, 1'b0, 32'h0000_0100, 32'h0000_01ff);
		g0 = grp;
		br(32'h0000_0080);
		settle;
		chk(grp, g0);
		br(32'h0000_0180);
		settle;
		chk(grp, g0 + 1);
		chk(addr, 32'h0000_0180);
		chk(mm, 4'h1);
	endtask
	task t_half;
		cfg(1'b1, `ITP_SEL_ALWAYS, 1'b1, 32'h0, 32'h0);
		br(32'h5a5a_c3c3);
		settle;
		chk(addr, 32'h5a5a_c3c3);
		chk(sy, 1'b0);
	endtask
	task t_port;
		do_reset(1'b0);
		chk(sel, 1'b0);
		chk(oe, 1'b0);
		chk(pin, 1'b1);
	endtask
	initial
	begin
		{b, w, ext, tck, tdi, sh, up, half} = '0;
		{v, c, rst, trst, strap_low} = '1;
		pc = '0;
		do_reset(1'b1);
		t_idle;
		t_branch;
		t_off;
		t_ext;
		t_cmp;
		t_half;
		t_port;
		summarize;
	end
	initial
	begin
		#100000;
		error_cnt++;
		summarize;
	end
endmodule

// file: verilog/itp_cfg.sv
`timescale 1ns/1ns
`include "itp_map.svh"
// configuration scan chain on the debugger clock, captured on update
module itp_cfg
	import itp_pkg::*;
(
	input wire logic tck_i,
	input wire logic trst_i,
	input wire logic tdi_i,
	input wire logic shift_i,
	input wire logic update_i,
	output logic tdo_o,
	output logic [`ITP_CFG_W-1:0] cfg_o
);
	logic [`ITP_CFG_W-1:0] shift_reg;
	always_ff @(posedge tck_i)
	begin
		if (trst_i)
		begin
			shift_reg <= '0;
			cfg_o <= '0;
		end
		else if (shift_i)
			shift_reg <= {tdi_i, shift_reg[`ITP_CFG_W-1:1]};
		else if (update_i)
			cfg_o <= shift_reg;
		else
			shift_reg <= cfg_o;
	end
	assign tdo_o = shift_reg[0];
endmodule

// file: verilog/itp_map.svh
`ifndef ITP_MAP_SVH
`define ITP_MAP_SVH
// pipeline status codes
`define ITP_PS_EXEC 3'h0
`define ITP_PS_NOEXEC 3'h1
`define ITP_PS_BRANCH 3'h4
`define ITP_PS_WAIT 3'h2
`define ITP_PS_TRIG 3'h6
// packet and address layout
`define ITP_PKT_BYTES 3'h4
`define ITP_NIB_LO 3:0
`define ITP_NIB_HI 7:4
// resource selector codes
`define ITP_SEL_ALWAYS 2'h0
`define ITP_SEL_CMP 2'h1
`define ITP_SEL_CNT 2'h2
`define ITP_SEL_EXT 2'h3
// configuration scan layout, lsb first
`define ITP_CFG_W 100
`define ITP_CFG_EN 0
`define ITP_CFG_HALF 1
`define ITP_CFG_SEL 3:2
`define ITP_CFG_LO 35:4
`define ITP_CFG_HI 67:36
`define ITP_CFG_CNT 83:68
`define ITP_CFG_MMD 91:84
`define ITP_CFG_RSV 99:92
`endif

// file: verilog/itp_pkg.sv
package itp_pkg;
	typedef enum logic [1:0] {ITP_IDLE, ITP_LO, ITP_HI} itp_tx_state_t;
	typedef logic [7:0] itp_byte_t;
endpackage

// file: verilog/itp_sync.sv
`timescale 1ns/1ns
// two-stage level synchroniser
module itp_sync
	import itp_pkg::*;
#(
	parameter int W = 1
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;
	initial
	begin
		if (W < 1) $error("itp_sync: width below one");
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

// file: verilog/itp_trace.sv
`timescale 1ns/1ns
`include "itp_map.svh"
// Notes on behaviour
// - status, sync and packet outputs change only on rising edges of the trace port clock.
// - a three-bit status code is driven every trace cycle describing the execute stage.
// - packet sync is high only while the low nibble of the first packet of a branch address group is out.
// - each eight-bit packet leaves as low nibble then high nibble on consecutive cycles.
// - only branch targets produce address packets, other cycles give status alone.
// - the trace port clock comes from outside; half-rate mode sends on alternate edges.
// - outputs are launched from the trace clock edge so the analyzer gets hold margin.
// - one address comparator pair, four memory map decoders and one counter exist.
// - no data comparators and no data trace; only instruction flow is traced.
// - trace is gated by a selected resource: comparator, counter, trigger or always.
// - one external trigger input acts as trace trigger source.
// - configuration is written and read only over the debugger scan port.
// - with tracing disabled the port outputs are forced to no-exec, sync and nibble low, group state holds, but the half-rate phase bit keeps toggling.
// - the unit watches core execute signals directly, not the system bus.
// - the packet sync pin is sampled during reset; low selects the trace pin function.
module itp_trace
	import itp_pkg::*;
#(
	parameter int ADDR_W = 32,
	parameter int CNT_W = 16
)
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic trace_port_clock,
	input wire logic core_exec_valid_i,
	input wire logic core_exec_cond_i,
	input wire logic core_branch_i,
	input wire logic core_wait_i,
	input wire logic [ADDR_W-1:0] core_pc_i,
	input wire logic external_trigger_in,
	input wire logic tck_i,
	input wire logic trst_i,
	input wire logic tdi_i,
	input wire logic cfg_shift_i,
	input wire logic cfg_update_i,
	output logic tdo_o,
	input wire logic packet_sync_pin_i,
	output logic packet_sync_pin_oe_o,
	output logic trace_pins_sel_o,
	output logic [2:0] pipeline_status_code,
	output logic packet_sync_flag,
	output logic [3:0] trace_packet_nibble,
	output logic [3:0] mem_map_hit_o
);
	initial
	begin
		if (ADDR_W != 32 || CNT_W != 16) $error("itp_trace: unsupported widths");
		if (`ITP_PKT_BYTES * $bits(itp_byte_t) != ADDR_W) $error("itp_trace: group size mismatch");
	end
	// ************************************************************
	// configuration, debugger side only
	// ************************************************************
	logic [`ITP_CFG_W-1:0] cfg_tck;
	itp_cfg u_cfg
	(
		.tck_i(tck_i),
		.trst_i(trst_i),
		.tdi_i(tdi_i),
		.shift_i(cfg_shift_i),
		.update_i(cfg_update_i),
		.tdo_o(tdo_o),
		.cfg_o(cfg_tck)
	);
	// static fields cross as levels; software changes them only while tracing is off
	logic [`ITP_CFG_W-1:0] cfg_sys;
	itp_sync #(.W(`ITP_CFG_W)) u_cfg_sync
	(
		.clk_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(cfg_tck),
		.q_o(cfg_sys)
	);
	logic [`ITP_CFG_W-1:0] cfg_trc;
	itp_sync #(.W(`ITP_CFG_W)) u_cfg_trc
	(
		.clk_i(trace_port_clock),
		.rst_i(rst_i),
		.d_i(cfg_tck),
		.q_o(cfg_trc)
	);
	// ************************************************************
	// pin strap caught at reset release
	// ************************************************************
	logic strap_s;
	itp_sync u_strap
	(
		.clk_i(clk_sys_i),
		.rst_i(1'b0),
		.d_i(packet_sync_pin_i),
		.q_o(strap_s)
	);
	logic trace_sel_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			trace_sel_reg <= ~strap_s;
	end
	assign trace_pins_sel_o = trace_sel_reg;
	assign packet_sync_pin_oe_o = trace_sel_reg & ~rst_i;
	// ************************************************************
	// trigger resources on the core clock
	// ************************************************************
	logic ext_s;
	itp_sync u_ext
	(
		.clk_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(external_trigger_in),
		.q_o(ext_s)
	);
	wire trace_en = cfg_sys[`ITP_CFG_EN] & trace_sel_reg;
	wire [ADDR_W-1:0] cmp_lo = cfg_sys[`ITP_CFG_LO];
	wire [ADDR_W-1:0] cmp_hi = cfg_sys[`ITP_CFG_HI];
	// one comparator pair, range inclusive; no data compare exists
	wire cmp_hit = core_exec_valid_i && core_pc_i >= cmp_lo && core_pc_i <= cmp_hi;
	// four memory map decoders, one per top-level quarter of the map
	wire [7:0] mmd_cfg = cfg_sys[`ITP_CFG_MMD];
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_mmd
			assign mem_map_hit_o[g] = core_exec_valid_i & mmd_cfg[g]
				& (core_pc_i[ADDR_W-1:ADDR_W-2] == 2'(g));
		end
	endgenerate
	logic [CNT_W-1:0] cnt_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || !trace_en)
			cnt_reg <= cfg_sys[`ITP_CFG_CNT];
		else if (cmp_hit && cnt_reg != '0)
			cnt_reg <= cnt_reg - 1'b1;
	end
	wire cnt_done = trace_en && cnt_reg == '0;
	wire [1:0] sel = cfg_sys[`ITP_CFG_SEL];
	wire gate_on = (sel == `ITP_SEL_ALWAYS) || (sel == `ITP_SEL_CMP && cmp_hit)
		|| (sel == `ITP_SEL_CNT && cnt_done) || (sel == `ITP_SEL_EXT && ext_s);
	// ************************************************************
	// event capture: one status per core cycle, address on branch
	// ************************************************************
	logic [2:0] ev_code;
	assign ev_code = core_wait_i ? `ITP_PS_WAIT
		: (!core_exec_valid_i || !core_exec_cond_i) ? `ITP_PS_NOEXEC
		: core_branch_i ? `ITP_PS_BRANCH : `ITP_PS_EXEC;
	wire want_addr = trace_en && gate_on && core_branch_i && core_exec_valid_i
		&& core_exec_cond_i && !core_wait_i;
	// handshake carries one branch address to the trace domain
	logic req_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic ack_s;
	wire busy = req_reg ^ ack_s;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			req_reg <= 1'b0;
			addr_reg <= '0;
		end
		else if (want_addr && !busy)
		begin
			req_reg <= ~req_reg;
			addr_reg <= core_pc_i;
		end
	end
	logic [2:0] code_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || !trace_en)
			code_reg <= `ITP_PS_NOEXEC;
		else
			code_reg <= (want_addr && busy) ? `ITP_PS_EXEC : ev_code;
	end
	// ************************************************************
	// trace clock domain
	// ************************************************************
	logic req_t;
	itp_sync u_req
	(
		.clk_i(trace_port_clock),
		.rst_i(rst_i),
		.d_i(req_reg),
		.q_o(req_t)
	);
	logic ack_reg;
	itp_sync u_ack
	(
		.clk_i(clk_sys_i),
		.rst_i(rst_i),
		.d_i(ack_reg),
		.q_o(ack_s)
	);
	logic [2:0] code_t;
	itp_sync #(.W(3)) u_code
	(
		.clk_i(trace_port_clock),
		.rst_i(rst_i),
		.d_i(code_reg),
		.q_o(code_t)
	);
	wire en_t = cfg_trc[`ITP_CFG_EN];
	wire half_t = cfg_trc[`ITP_CFG_HALF];
	logic phase_reg;
	always_ff @(posedge trace_port_clock)
	begin
		if (rst_i || !half_t)
			phase_reg <= 1'b0;
		else
			phase_reg <= ~phase_reg;
	end
	wire tick = en_t & (~half_t | phase_reg);
	itp_tx_state_t st_reg;
	itp_tx_state_t st_next;
	logic [ADDR_W-1:0] sh_reg;
	logic [2:0] left_reg;
	logic first_reg;
	wire new_req = req_t ^ ack_reg;
	wire load = tick && st_reg == ITP_IDLE && new_req;
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			ITP_IDLE: if (load) st_next = ITP_LO;
			ITP_LO: if (tick) st_next = ITP_HI;
			ITP_HI: if (tick) st_next = (left_reg == 3'h1) ? ITP_IDLE : ITP_LO;
		endcase
	end
	// ************************************************************
	// next values for the port, one per tick
	// ************************************************************
	// one group at a time; a fresh request waits for idle
	wire [ADDR_W-1:0] sh_after = sh_reg >> $bits(itp_byte_t);
	wire itp_byte_t cur_byte = sh_reg[7:0];
	wire itp_byte_t next_byte = itp_byte_t'(sh_after);
	wire go_lo = st_next == ITP_LO;
	wire go_hi = st_next == ITP_HI;
	// a refused branch shows as plain exec
	logic [2:0] stat_next;
	assign stat_next = load ? `ITP_PS_BRANCH
		: (code_t == `ITP_PS_BRANCH) ? `ITP_PS_EXEC : code_t;
	wire sync_next = go_lo && (load || first_reg && st_reg == ITP_IDLE);
	// low nibble of the byte about to leave, high nibble of the one out now
	logic [3:0] lo_nib;
	assign lo_nib = load ? addr_reg[`ITP_NIB_LO] : next_byte[`ITP_NIB_LO];
	logic [3:0] nib_next;
	assign nib_next = go_lo ? lo_nib : go_hi ? cur_byte[`ITP_NIB_HI] : 4'h0;
	// ************************************************************
	// group sequencing
	// ************************************************************
	always_ff @(posedge trace_port_clock)
	begin
		if (rst_i)
		begin
			st_reg <= ITP_IDLE;
			ack_reg <= 1'b0;
			sh_reg <= '0;
			left_reg <= 3'h0;
			first_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			if (load)
			begin
				ack_reg <= req_t;
				sh_reg <= addr_reg; // stable while handshake open
				left_reg <= `ITP_PKT_BYTES;
				first_reg <= 1'b1;
			end
			else if (tick && st_reg == ITP_HI)
			begin
				sh_reg <= sh_after;
				left_reg <= left_reg - 3'h1;
				first_reg <= 1'b0;
			end
		end
	end
	// outputs launched from the rising trace clock edge
	always_ff @(posedge trace_port_clock)
	begin
		if (rst_i || !en_t)
		begin
			pipeline_status_code <= `ITP_PS_NOEXEC;
			packet_sync_flag <= 1'b0;
			trace_packet_nibble <= 4'h0;
		end
		else if (tick)
		begin
			pipeline_status_code <= stat_next;
			packet_sync_flag <= sync_next;
			trace_packet_nibble <= nib_next;
		end
	end
endmodule
